// ### src/pidt_loop.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
module pidt_loop import pidt_pkg::*; #(
	parameter int CSEC_CYC = CSEC_CYC_DEF
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic temp_valid,
	input wire logic [4:0] temp_index,
	input wire logic [15:0] temp_value,
	output logic [NCH-1:0] relay_out,
	output logic alarm_output,
	output logic fault_flag
);
	generate
		if (CSEC_CYC < 2) begin : g_chk
			$error("CSEC_CYC must be at least 2");
		end
	endgenerate

	localparam int CW = $clog2(CSEC_CYC + 1);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic en;
		logic hc;
		logic en_d;
		logic [15:0] gain;
		logic [15:0] rstw;
		logic [15:0] ratew;
		logic [15:0] ivl;
		logic [15:0] hpd;
		logic [15:0] ovt;
		logic [7:0] first;
		logic [7:0] count;
		logic [7:0] hpt;
		logic [31:0] sel;
		logic [31:0] seen;
		logic [31:0] cfg_ok;
		logic [31:0] st_ok;
		logic [31:0] zone;
		logic [31:0] warn;
		logic [2:0] lcode;
		logic [2:0] pcode;
		logic rdy;
		logic fault;
		logic alarm;
		logic [CW-1:0] ccnt;
		logic ctick;
		logic [6:0] csec;
		logic stick;
		logic [5:0] lsec;
		logic pid_due;
		logic pass_pid;
		pidt_st_t st;
		logic [4:0] ch;
		logic swe;
		logic [59:0] sword;
		logic dwe;
		logic [DUTY_W-1:0] dval;
	} pidt_state_t;

	pidt_state_t r;
	pidt_state_t n;

	// Out-of-range codes fold to the 32 s setting
	function automatic logic [2:0] pidt_code(input logic [7:0] c);
		return (c >= CODE_MAX8) ? CODE_MAX : c[2:0];
	endfunction

	// Byte-lane merge of a bus write
	function automatic logic [31:0] pidt_wm(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (o & ~m) | (d & m);
	endfunction

	// ****************************************************************
	// Bus decode and channel masks
	// ****************************************************************
	logic req;
	logic wr;
	logic [11:0] ix;
	logic [4:0] sub;
	logic sp_hit;
	logic out_hit;
	logic run;
	logic [4:0] abs_ch;
	logic [NCH-1:0] act_abs;
	logic [NCH-1:0] act_rel;
	logic [5:0] lmax;
	logic [8:0] lperiod;

	assign req = wb_cyc_i & wb_stb_i & ~r.ack;
	assign wr = req & wb_we_i & (wb_adr_i[15:14] == 2'b00) & (wb_adr_i[1:0] == 2'b00);
	assign ix = wb_adr_i[13:2];
	assign sub = ix[4:0];
	assign sp_hit = (ix[11:5] == IX_SP[11:5]);
	assign out_hit = (ix[11:5] == IX_OUT[11:5]);
	assign run = r.en & r.rdy & ~r.fault;
	assign abs_ch = 5'(r.first + {3'b000, r.ch});
	assign lmax = 6'((7'h01 << r.lcode) - 7'h01);
	assign lperiod = 9'(LP_BASE << r.lcode);

	// Active channels, absolute and relative to the first index
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_act
			localparam logic [8:0] GI = 9'(gi);
			assign act_abs[gi] = (GI >= {1'b0, r.first}) && (GI < ({1'b0, r.first} + {1'b0, r.count}));
			assign act_rel[gi] = GI < {1'b0, r.count};
		end
	endgenerate

	// ****************************************************************
	// Memories and PWM
	// ****************************************************************
	logic [31:0] cfg_rd;
	logic [15:0] pv_rd;
	logic [59:0] st_rd;
	logic [NCH*DUTY_W-1:0] duty_flat;

	// Setpoint in low half, deviation band in high half
	pidt_mem #(.W(32), .D(NCH)) u_cfg (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.we(wr & sp_hit),
		.waddr(sub),
		.wdata(wb_dat_i),
		.raddr(abs_ch),
		.rdata(cfg_rd)
	);

	// Latest measured temperature per sensor channel
	pidt_mem #(.W(16), .D(NCH)) u_pv (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.we(temp_valid),
		.waddr(temp_index),
		.wdata(temp_value),
		.raddr(abs_ch),
		.rdata(pv_rd)
	);

	// Private per-channel loop state: power timer, scan count, integral, last value
	pidt_mem #(.W(60), .D(NCH)) u_st (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.we(r.swe),
		.waddr(r.ch),
		.wdata(r.sword),
		.raddr(r.ch),
		.rdata(st_rd)
	);

	pidt_pwm #(.N(NCH)) u_pwm (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ctick(r.ctick),
		.pcode(r.pcode),
		.run(run),
		.dwe(r.dwe),
		.didx(r.ch),
		.dval(r.dval),
		.duty_flat(duty_flat),
		.relay(relay_out)
	);

	// ****************************************************************
	// Loop arithmetic for the channel under calculation
	// ****************************************************************
	logic [15:0] sp;
	logic [15:0] dev;
	logic [59:0] stw;
	logic signed [17:0] diff;
	logic signed [17:0] err;
	logic signed [17:0] adiff;
	logic signed [17:0] dpv;
	logic signed [35:0] ig_sum;
	logic signed [23:0] ig_n;
	logic signed [34:0] dterm;
	logic signed [35:0] sum;
	logic signed [53:0] uq;
	logic [DUTY_W-1:0] u;
	logic [DUTY_W-1:0] cur_duty;
	logic zone_hit;
	logic [3:0] oc_n;
	logic [15:0] hp_n;

	// Unwritten memory words count as zero
	assign sp = r.cfg_ok[abs_ch] ? cfg_rd[15:0] : 16'h0000;
	assign dev = r.cfg_ok[abs_ch] ? cfg_rd[31:16] : 16'h0000;
	assign stw = r.st_ok[r.ch] ? st_rd : 60'h0;
	assign cur_duty = duty_flat[r.ch * DUTY_W +: DUTY_W];
	assign diff = $signed({2'b00, sp}) - $signed({2'b00, pv_rd});
	assign err = r.hc ? diff : -diff;
	assign adiff = diff[17] ? -diff : diff;
	assign zone_hit = adiff <= $signed({2'b00, dev});

	// Integral clamps so a long error cannot wind it without bound
	always_comb begin
		ig_sum = 36'($signed(stw[39:16])) + 36'(err) * 36'($signed({1'b0, r.rstw}));
		if (r.rstw == 16'h0000) begin
			ig_n = '0;
		end else if (ig_sum > ILIM) begin
			ig_n = 24'(ILIM);
		end else if (ig_sum < -ILIM) begin
			ig_n = 24'(-ILIM);
		end else begin
			ig_n = 24'(ig_sum);
		end
	end

	// Derivative on the measurement, signed to the control direction
	assign dpv = $signed({2'b00, pv_rd}) - $signed({2'b00, stw[15:0]});
	assign dterm = (r.ratew == 16'h0000) ? 35'sh0 :
		35'(r.hc ? -dpv : dpv) * 35'($signed({1'b0, r.ratew}));
	assign sum = 36'(err) + 36'(ig_n >>> INT_SH) + 36'(dterm >>> DER_SH);
	assign uq = (sum * $signed({1'b0, r.gain})) >>> OUT_SH;
	assign u = (uq <= 0) ? '0 : (uq >= UMAX) ? DUTY_W'(UMAX) : uq[DUTY_W-1:0];

	// Per-scan supervision counters
	assign oc_n = (pv_rd >= r.ovt) ? ((stw[43:40] == OVT_SCANS) ? OVT_SCANS :
		stw[43:40] + 4'h1) : 4'h0;
	assign hp_n = (({1'b0, cur_duty} >= r.hpt) && !zone_hit) ? ((stw[59:44] == HP_SAT) ?
		HP_SAT : stw[59:44] + 16'h0001) : 16'h0000;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		logic [31:0] wv;
		wv = pidt_wm(32'h0000_0000, wb_dat_i, wb_sel_i);
		n = r;
		n.ack = req;
		n.swe = 1'b0;
		n.dwe = 1'b0;
		n.en_d = r.en;

		// Register reads answer one cycle after the request
		if (req && !wb_we_i) begin
			n.dat = 32'h0000_0000;
			if (out_hit) begin
				n.dat = {25'h0, duty_flat[sub * DUTY_W +: DUTY_W]};
			end else begin
				case (ix)
					IX_CTRL: n.dat = {30'h0, r.hc, r.en};
					IX_GAIN: n.dat = {16'h0000, r.gain};
					IX_RSTW: n.dat = {16'h0000, r.rstw};
					IX_RATEW: n.dat = {16'h0000, r.ratew};
					IX_FIRST: n.dat = {24'h00_0000, r.first};
					IX_COUNT: n.dat = {24'h00_0000, r.count};
					IX_STAT: n.dat = {7'h00, lperiod, 13'h0000, r.alarm, r.fault, r.rdy};
					IX_IVL: n.dat = {16'h0000, r.ivl};
					IX_HPT: n.dat = {24'h00_0000, r.hpt};
					IX_HPD: n.dat = {16'h0000, r.hpd};
					IX_OVT: n.dat = {16'h0000, r.ovt};
					IX_SEL_LO: n.dat = {16'h0000, r.sel[15:0]};
					IX_SEL_HI: n.dat = {16'h0000, r.sel[31:16]};
					IX_WA: n.dat = {16'h0000, r.zone[15:0]};
					IX_WA + 12'h001: n.dat = {16'h0000, r.zone[31:16]};
					IX_WA + 12'h002: n.dat = {16'h0000, r.warn[15:0]};
					IX_WA + 12'h003: n.dat = {16'h0000, r.warn[31:16]};
					default: n.dat = 32'h0000_0000;
				endcase
			end
		end

		// Register writes; work area and status ignore them
		if (wr) begin
			if (sp_hit) begin
				n.cfg_ok[sub] = 1'b1;
			end
			case (ix)
				IX_CTRL: begin
					wv = pidt_wm({30'h0, r.hc, r.en}, wb_dat_i, wb_sel_i);
					n.en = wv[0];
					n.hc = wv[1];
				end
				IX_GAIN: begin
					wv = pidt_wm({16'h0000, r.gain}, wb_dat_i, wb_sel_i);
					n.gain = wv[15:0];
				end
				IX_RSTW: begin
					wv = pidt_wm({16'h0000, r.rstw}, wb_dat_i, wb_sel_i);
					n.rstw = wv[15:0];
				end
				IX_RATEW: begin
					wv = pidt_wm({16'h0000, r.ratew}, wb_dat_i, wb_sel_i);
					n.ratew = wv[15:0];
				end
				IX_FIRST: begin
					wv = pidt_wm({24'h00_0000, r.first}, wb_dat_i, wb_sel_i);
					n.first = wv[7:0];
				end
				IX_COUNT: begin
					wv = pidt_wm({24'h00_0000, r.count}, wb_dat_i, wb_sel_i);
					n.count = wv[7:0];
				end
				IX_IVL: begin
					wv = pidt_wm({16'h0000, r.ivl}, wb_dat_i, wb_sel_i);
					n.ivl = wv[15:0];
				end
				IX_HPT: begin
					wv = pidt_wm({24'h00_0000, r.hpt}, wb_dat_i, wb_sel_i);
					if (wv[7:0] >= HPT_MIN && wv[7:0] <= HPT_MAX && wv[31:8] == 24'h00_0000) begin
						n.hpt = wv[7:0];
					end
				end
				IX_HPD: begin
					wv = pidt_wm({16'h0000, r.hpd}, wb_dat_i, wb_sel_i);
					if (wv[15:0] >= HPD_MIN) begin
						n.hpd = wv[15:0];
					end
				end
				IX_OVT: begin
					wv = pidt_wm({16'h0000, r.ovt}, wb_dat_i, wb_sel_i);
					n.ovt = wv[15:0];
				end
				IX_SEL_LO: begin
					wv = pidt_wm({16'h0000, r.sel[15:0]}, wb_dat_i, wb_sel_i);
					n.sel[15:0] = wv[15:0];
				end
				IX_SEL_HI: begin
					wv = pidt_wm({16'h0000, r.sel[31:16]}, wb_dat_i, wb_sel_i);
					n.sel[31:16] = wv[15:0];
				end
				default: n.hpt = r.hpt;
			endcase
		end

		// Sensor coverage and configuration check
		if (temp_valid) begin
			n.seen[temp_index] = 1'b1;
		end
		n.rdy = &(r.seen | ~act_abs);
		n.fault = (r.first > FIRST_MAX) || (r.count == 8'h00) || (r.count > COUNT_RST) ||
			(({1'b0, r.first} + {1'b0, r.count}) > SUM_MAX);
		n.alarm = run && ((|(act_rel & ~r.zone)) || (|r.warn));

		// Centisecond and second time base
		n.ctick = 1'b0;
		n.stick = 1'b0;
		n.ccnt = r.ccnt + CW'(1);
		if (r.ccnt == CW'(CSEC_CYC - 1)) begin
			n.ccnt = '0;
			n.ctick = 1'b1;
		end
		if (r.ctick) begin
			n.csec = r.csec + 7'h01;
			if (r.csec == CSEC_TOP) begin
				n.csec = 7'h00;
				n.stick = 1'b1;
			end
		end

		// Warnings restart on enable rise; one raised in the same cycle still lands
		if (r.en && !r.en_d) begin
			n.warn = 32'h0000_0000;
		end

		// One supervision sweep per second; loop passes are the marked ones
		case (r.st)
			S_IDLE: begin
				if (r.stick && run) begin
					n.st = S_FETCH;
					n.ch = 5'h00;
					n.pass_pid = r.pid_due;
					n.pid_due = 1'b0;
				end
			end
			S_FETCH: n.st = S_CALC;
			S_CALC: begin
				n.st = S_STORE;
				n.swe = 1'b1;
				n.st_ok[r.ch] = 1'b1;
				n.zone[r.ch] = zone_hit;
				if (oc_n == OVT_SCANS || hp_n >= r.hpd) begin
					n.warn[r.ch] = 1'b1;
				end
				n.sword = {hp_n, oc_n, stw[39:0]};
				if (!r.sel[r.ch]) begin
					n.sword[39:0] = {24'h00_0000, pv_rd};
					n.dwe = 1'b1;
					n.dval = '0;
				end else if (r.pass_pid) begin
					n.sword[39:0] = {ig_n, pv_rd};
					n.dwe = 1'b1;
					n.dval = u;
				end
			end
			S_STORE: begin
				if ({3'b000, r.ch} + 8'h01 >= r.count) begin // Ends even if count shrank
					n.st = S_IDLE;
				end else begin
					n.ch = r.ch + 5'h01;
					n.st = S_FETCH;
				end
			end
			default: n.st = S_IDLE;
		endcase

		// Loop interval counted in seconds while running
		if (r.stick && run) begin
			n.lsec = r.lsec + 6'h01;
			if (r.lsec >= lmax) begin
				n.lsec = 6'h00;
				n.pid_due = 1'b1;
			end
		end

		// Enable rising: take the interval settings, restart the loop
		if (r.en && !r.en_d) begin
			n.lcode = pidt_code(r.ivl[7:0]);
			n.pcode = pidt_code(r.ivl[15:8]);
			n.lsec = 6'h00;
			n.pid_due = 1'b1;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= S_IDLE;
			r.gain <= GAIN_RST;
			r.rstw <= RSTW_RST;
			r.ratew <= RATEW_RST;
			r.ivl <= IVL_RST;
			r.lcode <= IVL_RST[2:0];
			r.pcode <= IVL_RST[10:8];
			r.hpt <= HPT_RST;
			r.hpd <= HPD_RST;
			r.ovt <= OVT_RST;
			r.sel <= SEL_RST;
			r.first <= FIRST_RST;
			r.count <= COUNT_RST;
		end else begin
			r <= n;
		end
	end

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign alarm_output = r.alarm;
	assign fault_flag = r.fault;
endmodule // pidt_loop

// ### src/pidt_pkg.sv
// How it works
// - Loop period is one of 10, 20, 40, 80, 160, 320 tenths of a second.
// - Reset weight of zero removes the integral term from the output.
// - Rate weight of zero removes the derivative term from the output.
// - After reset the loop recomputes every 4 seconds (code 2).
// - Proportional gain resets to 110.
// - Reset weight resets to 17.
// - Rate weight resets to 50.
// - Nothing runs until every active temperature channel was sampled once.
// - Heat_cool_select 1 heats, 0 cools; sign of error follows it.
// - Each result is readable per channel and drives a relay pulse.
// - Bad first index, count or sum stops work and raises fault_flag.
// - In-zone bit follows deviation band; out of band raises alarm_output.
// - Ten scans at or above overtemp limit set warning and alarm.
// - High power too long without reaching band sets warning and alarm.
// - Nine-word work area; words 0-1 hold in-zone bits, bit n = channel first+n.
// - Words 2-3 hold warning bits with the same channel mapping.
// - Interval low byte codes 0-4 give 1-16 s, 5 or more 32 s, default 2.
// - Interval high byte sets PWM cycle the same way, default 1.
// - Deselected channels get no computation and their relay stays off.
// - Power threshold 80-100 percent, default 90; duration 60-65535 s, default 600.
package pidt_pkg;
	// ****************************************************************
	// Sizes and timing
	// ****************************************************************
	localparam int NCH = 32;
	localparam int DUTY_W = 7;
	localparam int CLK_HZ = 32'h0131_2d00;
	localparam int CSEC_MS = 32'h0000_000a;
	localparam int CSEC_CYC_DEF = CLK_HZ / 32'h0000_03e8 * CSEC_MS;
	localparam logic [6:0] CSEC_TOP = 7'h63;
	localparam logic [11:0] PWM_STEPS = 12'h064;
	localparam logic [8:0] LP_BASE = 9'h00a;

	// ****************************************************************
	// Register indexes (byte address is four times the index)
	// ****************************************************************
	localparam logic [11:0] IX_CTRL = 12'hf90;
	localparam logic [11:0] IX_GAIN = 12'hf91;
	localparam logic [11:0] IX_RSTW = 12'hf92;
	localparam logic [11:0] IX_RATEW = 12'hf93;
	localparam logic [11:0] IX_FIRST = 12'hf94;
	localparam logic [11:0] IX_COUNT = 12'hf95;
	localparam logic [11:0] IX_STAT = 12'hf96;
	localparam logic [11:0] IX_IVL = 12'hfa5;
	localparam logic [11:0] IX_HPT = 12'hfa6;
	localparam logic [11:0] IX_HPD = 12'hfa7;
	localparam logic [11:0] IX_OVT = 12'hfa8;
	localparam logic [11:0] IX_SEL_LO = 12'hfac;
	localparam logic [11:0] IX_SEL_HI = 12'hfad;
	localparam logic [11:0] IX_WA = 12'hfb0;
	localparam logic [11:0] IX_WA_LAST = 12'hfb8;
	localparam logic [11:0] IX_SP = 12'he00;
	localparam logic [11:0] IX_OUT = 12'he40;

	// ****************************************************************
	// Reset values and limits
	// ****************************************************************
	localparam logic [15:0] GAIN_RST = 16'h006e;
	localparam logic [15:0] RSTW_RST = 16'h0011;
	localparam logic [15:0] RATEW_RST = 16'h0032;
	localparam logic [15:0] IVL_RST = 16'h0102;
	localparam logic [7:0] HPT_RST = 8'h5a;
	localparam logic [7:0] HPT_MIN = 8'h50;
	localparam logic [7:0] HPT_MAX = 8'h64;
	localparam logic [15:0] HPD_RST = 16'h0258;
	localparam logic [15:0] HPD_MIN = 16'h003c;
	localparam logic [15:0] OVT_RST = 16'h0dac;
	localparam logic [31:0] SEL_RST = 32'hffff_ffff;
	localparam logic [7:0] FIRST_RST = 8'h00;
	localparam logic [7:0] FIRST_MAX = 8'h1f;
	localparam logic [7:0] COUNT_RST = 8'h20;
	localparam logic [8:0] SUM_MAX = 9'h020;
	localparam logic [7:0] CODE_MAX8 = 8'h05;
	localparam logic [2:0] CODE_MAX = 3'h5;
	localparam logic [3:0] OVT_SCANS = 4'ha;
	localparam logic [15:0] HP_SAT = 16'hffff;
	localparam logic signed [35:0] ILIM = 36'sh0_007f_ffff;
	localparam logic signed [53:0] UMAX = 54'sh00_0000_0000_0064;
	localparam int INT_SH = 11;
	localparam int DER_SH = 7;
	localparam int OUT_SH = 7;

	// Sweep states, Gray from IDLE through STORE; STORE back to FETCH flips both bits
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_FETCH = 2'b01,
		S_CALC = 2'b11,
		S_STORE = 2'b10
	} pidt_st_t;
endpackage

// ### src/pidt_mem.sv
`timescale 1ns/10ps
module pidt_mem #(
	parameter int W = 16,
	parameter int D = 32,
	localparam int AW = $clog2(D)
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	generate
		if (D < 2 || W < 1) begin : g_chk
			$error("pidt_mem needs D >= 2 and W >= 1");
		end
	endgenerate

	logic [W-1:0] mem [D];

	// Array has no reset; readers track validity themselves
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read port, one cycle latency
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // pidt_mem

// ### src/pidt_pwm.sv
`timescale 1ns/10ps
module pidt_pwm import pidt_pkg::*; #(
	parameter int N = NCH,
	localparam int IW = $clog2(N)
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ctick,
	input wire logic [2:0] pcode,
	input wire logic run,
	input wire logic dwe,
	input wire logic [IW-1:0] didx,
	input wire logic [DUTY_W-1:0] dval,
	output logic [N*DUTY_W-1:0] duty_flat,
	output logic [N-1:0] relay
);
	generate
		if (N < 2 || N > NCH) begin : g_chk
			$error("pidt_pwm supports 2 to 32 channels");
		end
	endgenerate

	typedef struct packed {
		logic [N-1:0][DUTY_W-1:0] duty;
		logic [N-1:0] relay;
		logic [11:0] phase;
	} pidt_pwm_t;

	pidt_pwm_t r;
	pidt_pwm_t n;
	logic [N-1:0] on;
	logic [11:0] ptop;

	// One PWM cycle is 100 centisecond steps times two to the code
	assign ptop = 12'((PWM_STEPS << pcode) - 12'h001);

	// On while phase is below the duty scaled to the cycle
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_on
			assign on[g] = run && (12'({5'h00, r.duty[g]} << pcode) > r.phase);
		end
	endgenerate

	// Next state
	always_comb begin
		n = r;
		if (ctick) begin
			n.phase = (r.phase >= ptop) ? 12'h000 : r.phase + 12'h001;
		end
		if (dwe && (int'(didx) < N)) begin
			n.duty[didx] = dval;
		end
		n.relay = on;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign duty_flat = r.duty;
	assign relay = r.relay;
endmodule // pidt_pwm

// ### dv/pidt_loop_props.sv
`timescale 1ns/10ps
module pidt_loop_props import pidt_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [NCH-1:0] relay_out,
	input wire logic alarm_output,
	input wire logic fault_flag
);
	// ****************************************************************
	// Bus and output checks
	// ****************************************************************
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Request taken, then read answers by index
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd(logic [11:0] ix);
		wb_ack_o && !wb_we_i && wb_adr_i == {2'b00, ix, 2'b00};
	endsequence
	property p_ack_resp;
		s_take |=> wb_ack_o;
	endproperty
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_no_ack;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	// Three cycles of fault cover the register lag
	property p_fault_relay;
		fault_flag [*3] |-> relay_out == '0;
	endproperty
	property p_fault_alarm;
		fault_flag [*3] |-> !alarm_output;
	endproperty
	property p_stat_lp;
		s_rd(IX_STAT) |-> wb_dat_o[24:16] inside {9'h00a, 9'h014, 9'h028, 9'h050,
			9'h0a0, 9'h140};
	endproperty
	property p_ivl_hi;
		s_rd(IX_IVL) |-> wb_dat_o[31:16] == 16'h0000;
	endproperty
	property p_duty_max;
		wb_ack_o && !wb_we_i && wb_adr_i[15:7] == 9'h072 |-> wb_dat_o <= 32'h0000_0064;
	endproperty
	property p_sp_zero;
		wb_ack_o && !wb_we_i && wb_adr_i[15:7] == 9'h070 |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	a_no_ack: assert property (p_no_ack) else $error("ack without request");
	a_fault_relay: assert property (p_fault_relay) else $error("relay on in fault");
	a_fault_alarm: assert property (p_fault_alarm) else $error("alarm in fault");
	a_stat_lp: assert property (p_stat_lp) else $error("bad loop period");
	a_ivl_hi: assert property (p_ivl_hi) else $error("interval upper bits set");
	a_duty_max: assert property (p_duty_max) else $error("result above full");
	a_sp_zero: assert property (p_sp_zero) else $error("setpoint window not zero");
endmodule // pidt_loop_props

bind pidt_loop pidt_loop_props pidt_loop_props_inst (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.relay_out(relay_out),
	.alarm_output(alarm_output),
	.fault_flag(fault_flag)
);

// ### dv/pidt_temp_model.sv
`timescale 1ns/10ps
module pidt_temp_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic go,
	output logic temp_valid,
	output logic [4:0] temp_index,
	output logic [15:0] temp_value
);
	// Sweep all sensors, strobe every other clock; value inverted between strobes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_valid <= 1'b0;
			temp_index <= 5'h00;
			temp_value <= 16'h0000;
		end else begin
			temp_valid <= go && !temp_valid;
			temp_value <= (go && !temp_valid) ? 16'h00c8 : 16'hff37;
			if (temp_valid) begin
				temp_index <= temp_index + 5'h01;
			end
		end
	end
endmodule // pidt_temp_model

// ### dv/tb_top.sv
`timescale 1ns/10ps
module tb_top import pidt_pkg::*; ;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic go = 1'b0;
	logic [15:0] adr = 16'h0000;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack, tv, alarm, fault;
	logic [4:0] ti;
	logic [15:0] tval;
	logic [NCH-1:0] relay;
	wire logic [3:0] obs = {relay[1], relay[0], alarm, fault};
	int fails = 0;
	int samples_checked = 0;
	// Short centisecond so a second is 400 clocks
	always #25 core_clk = ~core_clk;
	pidt_loop #(.CSEC_CYC(4)) pidt_loop_inst (.core_clk(core_clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.temp_valid(tv), .temp_index(ti), .temp_value(tval), .relay_out(relay),
		.alarm_output(alarm), .fault_flag(fault));
	pidt_temp_model pidt_temp_model_inst (.core_clk(core_clk), .rst_n(rst_n), .go(go),
		.temp_valid(tv), .temp_index(ti), .temp_value(tval));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		end
	endtask
	// Classic cycle: hold until ack is sampled, then release
	task wb(input logic w, input logic [11:0] ix, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {2'b00, ix, 2'b00};
		dat <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			fails++;
			report_and_stop;
		end
	endtask
	task rd(input logic [11:0] ix, input logic [31:0] e);
		wb(1'b0, ix, 32'h0000_0000);
		chk("register", q, e);
	endtask
	// Bounded wait for one observed output bit
	task wait_bit(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (obs[k] !== v && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		chk("output bit", {31'h0, obs[k]}, {31'h0, v});
		if (obs[k] !== v) report_and_stop;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_defaults;
		logic [11:0] ix [11] = '{IX_GAIN, IX_RSTW, IX_RATEW, IX_IVL, IX_HPT, IX_HPD,
			IX_OVT, IX_SEL_LO, IX_FIRST, IX_COUNT, 12'h123};
		logic [31:0] e [11] = '{32'h006e, 32'h0011, 32'h0032, 32'h0102, 32'h005a,
			32'h0258, 32'h0dac, 32'hffff, 32'h0000, 32'h0020, 32'h0000};
		for (int i = 0; i < 11; i++) rd(ix[i], e[i]);
		wb(1'b0, IX_STAT, 32'h0000_0000);
		chk("period", {23'h0, q[24:16]}, 32'h0028);
	endtask
	task t_fault;
		wb(1'b1, IX_COUNT, 32'h0000_0000);
		wait_bit(0, 1'b1, 50);
		wb(1'b1, IX_COUNT, 32'h0000_0002);
		wait_bit(0, 1'b0, 50);
		wb(1'b1, IX_FIRST, 32'h0000_001f);
		wait_bit(0, 1'b1, 50);
		wb(1'b1, IX_FIRST, 32'h0000_0000);
		wb(1'b1, IX_COUNT, 32'h0000_0020);
		wait_bit(0, 1'b0, 50);
	endtask
	task t_limits;
		wb(1'b1, IX_HPT, 32'h0000_004f);
		rd(IX_HPT, 32'h0000_005a);
		wb(1'b1, IX_HPT, 32'h0000_0064);
		rd(IX_HPT, 32'h0000_0064);
		wb(1'b1, IX_WA, 32'h0000_ffff);
		rd(IX_WA, 32'h0000_0000);
		wb(1'b1, IX_WA + 12'h004, 32'h0000_ffff);
		rd(IX_WA + 12'h004, 32'h0000_0000);
	endtask
	task t_interval;
		logic [31:0] c [6] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h9};
		logic [31:0] e [6] = '{32'h000a, 32'h0014, 32'h0028, 32'h0050, 32'h00a0, 32'h0140};
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, IX_CTRL, 32'h0000_0000);
			wb(1'b1, IX_IVL, c[i]);
			wb(1'b1, IX_CTRL, 32'h0000_0001);
			wb(1'b0, IX_STAT, 32'h0000_0000);
			chk("period", {23'h0, q[24:16]}, e[i]);
		end
		wb(1'b1, IX_CTRL, 32'h0000_0000);
		wb(1'b1, IX_IVL, 32'h0000_0000);
	endtask
	task t_run;
		logic seen1;
		wb(1'b1, IX_SP, 32'h000a_03e8);
		wb(1'b1, IX_SEL_LO, 32'h0000_0001);
		wb(1'b1, IX_OVT, 32'h0000_0064);
		wb(1'b1, IX_CTRL, 32'h0000_0003);
		repeat (1200) @(posedge core_clk);
		chk("idle outputs", {28'h0, obs}, 32'h0000_0000);
		go <= 1'b1;
		wait_bit(2, 1'b1, 4000);
		wait_bit(1, 1'b1, 2000);
		seen1 = 1'b0;
		repeat (800) @(posedge core_clk) seen1 = seen1 | (relay[1] !== 1'b0);
		chk("deselected relay", {31'h0, seen1}, 32'h0000_0000);
		rd(IX_OUT, 32'h0000_0064);
		wb(1'b0, IX_WA, 32'h0000_0000);
		chk("in zone bit", {31'h0, q[0]}, 32'h0000_0000);
		repeat (4400) @(posedge core_clk);
		wb(1'b0, IX_WA + 12'h002, 32'h0000_0000);
		chk("warning bit", {31'h0, q[0]}, 32'h0000_0001);
		// Configuration fault while running drops relays and alarm
		wb(1'b1, IX_COUNT, 32'h0000_0000);
		wait_bit(2, 1'b0, 50);
		wait_bit(1, 1'b0, 50);
		wb(1'b1, IX_COUNT, 32'h0000_0020);
		wait_bit(2, 1'b1, 50);
		// Cooling is a fresh start after the heating run ends
		wb(1'b1, IX_CTRL, 32'h0000_0000);
		wb(1'b1, IX_CTRL, 32'h0000_0001);
		wait_bit(2, 1'b1, 50);
		wait_bit(2, 1'b0, 2000);
	endtask
	// Reset for 20 clocks, then the scenarios in order
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_defaults();
		t_fault();
		t_limits();
		t_interval();
		t_run();
		report_and_stop;
	end
endmodule // tb_top
